// ### bench/mcg_top_asserts.sv
// Concurrent checks on the ports of the clock generation top.
`timescale 1ns/1ps
`include "mcg_cfg.svh"
module mcg_top_asserts #(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Register bus.
    input wire logic [`MCG_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Configuration.
    input wire logic [1:0] cfg_src_i,
    input wire logic rtc_uses_xtal_i,
    // Clock outputs.
    input wire logic osc_tick_o,
    input wire logic cpu_tick_o,
    input wire logic machine_tick_o,
    input wire logic periph_tick_o,
    input wire logic clock_output_pin_o,
    input wire logic clock_output_pin_oe_n_o,
    input wire logic low_power_clock_o
);
    // Write to the auxiliary register and the bit value it should leave behind.
    wire aux_wr = s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o
        && s_axi_awaddr_i == `MCG_OFF_AUX1 && s_axi_wstrb_i[0];
    logic lp_want;
    always_ff @(posedge clk_i)
    begin
        if (aux_wr)
            lp_want <= s_axi_wdata_i[7];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // ****************************************************************
    // Bus handshakes
    // ****************************************************************
    sequence s_write_taken;
        s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    a_write_answer: assert property (s_write_taken |=> s_axi_bvalid_o)
        else $error("write response missing");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid_o)
        else $error("read response missing");
    a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
    a_map_decerr: assert property ((s_write_taken ##0 (s_axi_awaddr_i > `MCG_OFF_STATUS))
        |=> s_axi_bresp_o == `MCG_RESP_DECERR) else $error("unmapped write not refused");

    // ****************************************************************
    // Clock behaviour
    // ****************************************************************
    a_low_power_set: assert property (aux_wr |=> low_power_clock_o == lp_want)
        else $error("low power output does not follow register");
    a_reset_quiet: assert property ($fell(srst_i) |-> !low_power_clock_o
        && clock_output_pin_oe_n_o && !s_axi_bvalid_o && !s_axi_rvalid_o && !cpu_tick_o)
        else $error("outputs not quiet after reset");
    a_periph_pair: assert property (periph_tick_o |-> $past(cpu_tick_o) && !machine_tick_o)
        else $error("peripheral tick without cpu tick");
    a_machine_pair: assert property (machine_tick_o |-> $past(cpu_tick_o))
        else $error("machine tick without cpu tick");
    a_cpu_from_osc: assert property (cpu_tick_o |-> osc_tick_o)
        else $error("cpu tick without oscillator tick");
    a_pin_rate: assert property ($rose(clock_output_pin_o) |-> $past(cpu_tick_o))
        else $error("clock pin rose without cpu tick");
    a_xtal_no_out: assert property ((cfg_src_i == 2'b10 || rtc_uses_xtal_i)
        |-> clock_output_pin_oe_n_o && !clock_output_pin_o) else $error("clock pin driven");
endmodule : mcg_top_asserts

// ### bench/test_mcu_clock_generation.sv
// Self-checking bench of the clock generation top over its register bus.
`timescale 1ns/1ps
`include "mcg_cfg.svh"
module test_mcu_clock_generation;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [1:0] cfg_src_i = 2'b11;
    logic cfg_doubler_i = 1'b0, rtc_uses_xtal_i = 1'b0, ext_run = 1'b0;
    logic [5:0] factory_trim_i = 6'h2a;
    logic xtal_osc_i = 1'b0, ext_clk_i = 1'b0, wdt_osc_i = 1'b0;
    logic osc_tick_o, cpu_tick_o, machine_tick_o, periph_tick_o;
    logic clock_output_pin_o, clock_output_pin_oe_n_o, low_power_clock_o;
    logic [7:0] tv [3] = '{8'hc0, 8'hff, 8'he0};
    int failures = 0, num_checks = 0, phase = 0;
    int n_osc, n_cpu, n_per, n_mac, n_pin;

    mcg_top dut_u (.*);

    // System clock of 50 ns period.
    always #25 clk_i = ~clk_i;

    // Crystal and watchdog inputs run every 4 cycles, the external clock every 8 on request.
    always @(posedge clk_i)
    begin
        phase <= phase + 1;
        xtal_osc_i <= phase[1];
        wdt_osc_i <= phase[1];
        ext_clk_i <= ext_run & phase[2];
    end

    // ****************************************************************
    // Helper tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Counted rates pass when within a few ticks of the expected figure.
    task automatic check_near(input int seen, input int exp, input int tol);
        check(seen, (seen >= exp - tol && seen <= exp + tol) ? seen : exp);
    endtask : check_near

    task automatic guard(input int i);
        if (i >= 100)
        begin
            check(32'h0, 32'h1);
            results();
        end
    endtask : guard

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int i;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        @(negedge clk_i);
        for (i = 0; i < 100 && (s_axi_awready_o & s_axi_wready_o) !== 1'b1; i++) @(negedge clk_i);
        guard(i);
        @(posedge clk_i);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        @(negedge clk_i);
        for (i = 0; i < 100 && s_axi_bvalid_o !== 1'b1; i++) @(negedge clk_i);
        guard(i);
        check(s_axi_bresp_o, er);
        @(posedge clk_i);
        s_axi_bready_i <= 1'b1;
        @(posedge clk_i);
        s_axi_bready_i <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        @(negedge clk_i);
        for (i = 0; i < 100 && s_axi_arready_o !== 1'b1; i++) @(negedge clk_i);
        guard(i);
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        @(negedge clk_i);
        for (i = 0; i < 100 && s_axi_rvalid_o !== 1'b1; i++) @(negedge clk_i);
        guard(i);
        check(s_axi_rdata_o, ed);
        check(s_axi_rresp_o, er);
        @(posedge clk_i);
        s_axi_rready_i <= 1'b1;
        @(posedge clk_i);
        s_axi_rready_i <= 1'b0;
    endtask : axi_read

    task automatic count(input int n);
        logic last;
        n_osc = 0;
        n_cpu = 0;
        n_per = 0;
        n_mac = 0;
        n_pin = 0;
        last = clock_output_pin_o;
        repeat (n)
        begin
            @(negedge clk_i);
            n_osc += osc_tick_o;
            n_cpu += cpu_tick_o;
            n_per += periph_tick_o;
            n_mac += machine_tick_o;
            n_pin += (clock_output_pin_o !== last);
            last = clock_output_pin_o;
        end
        @(posedge clk_i);
    endtask : count

    task automatic reset_dut(input logic [1:0] src, input logic dbl, input logic rtc);
        cfg_src_i <= src;
        cfg_doubler_i <= dbl;
        rtc_uses_xtal_i <= rtc;
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask : reset_dut

    // Run-time limit.
    initial
    begin
        #5000000;
        check(32'h0, 32'h1);
        results();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        reset_dut(2'b11, 1'b0, 1'b0);
        axi_read(`MCG_OFF_TUNING, 32'h2a, `MCG_RESP_OKAY);
        axi_read(`MCG_OFF_DIVIDER, 32'h0, `MCG_RESP_OKAY);
        axi_read(`MCG_OFF_AUX1, 32'h0, `MCG_RESP_OKAY);
        axi_read(`MCG_OFF_STATUS, 32'h03, `MCG_RESP_OKAY);
        axi_read(8'h10, 32'h0, `MCG_RESP_DECERR);
        axi_write(8'h20, 32'hff, 4'hf, `MCG_RESP_DECERR);
        axi_write(`MCG_OFF_STATUS, 32'hff, 4'hf, `MCG_RESP_OKAY);
        axi_write(`MCG_OFF_AUX1, 32'h80, 4'h0, `MCG_RESP_OKAY);
        axi_read(`MCG_OFF_AUX1, 32'h0, `MCG_RESP_OKAY);
        axi_write(`MCG_OFF_AUX1, 32'h80, 4'hf, `MCG_RESP_OKAY);
        check(low_power_clock_o, 1'b1);
        // Undivided external clock, then divided by four.
        ext_run <= 1'b1;
        count(800);
        check_near(n_osc, 100, 2);
        check_near(n_cpu, n_osc, 1);
        check_near(n_per, n_cpu / 2, 1);
        check_near(n_mac, n_cpu / 2, 1);
        axi_write(`MCG_OFF_DIVIDER, 32'h2, 4'hf, `MCG_RESP_OKAY);
        count(800);
        check_near(n_cpu, 25, 2);
        check(n_pin, 0);
        check(clock_output_pin_oe_n_o, 1'b1);
        axi_write(`MCG_OFF_TUNING, 32'h6a, 4'hf, `MCG_RESP_OKAY);
        count(800);
        check(clock_output_pin_oe_n_o, 1'b0);
        check_near(n_pin, n_cpu, 1);
        axi_read(`MCG_OFF_STATUS, 32'hc3, `MCG_RESP_OKAY);
        // RC oscillator picked by the select bit at three trim settings.
        ext_run <= 1'b0;
        axi_write(`MCG_OFF_DIVIDER, 32'h0, 4'hf, `MCG_RESP_OKAY);
        for (int k = 0; k < 3; k++)
        begin
            axi_write(`MCG_OFF_TUNING, tv[k], 4'hf, `MCG_RESP_OKAY);
            axi_read(`MCG_OFF_TUNING, tv[k], `MCG_RESP_OKAY);
            count(2000);
            check_near(n_osc, (`MCG_RC_NOM_KHZ + (32 - int'(tv[k][5:0])) * 60) / 10, 5);
        end
        reset_dut(2'b11, 1'b1, 1'b0);
        axi_read(`MCG_OFF_TUNING, 32'h2a, `MCG_RESP_OKAY);
        axi_write(`MCG_OFF_TUNING, 32'ha0, 4'hf, `MCG_RESP_OKAY);
        count(2000);
        check_near(n_osc, 2 * `MCG_RC_NOM_KHZ / 10, 5);
        reset_dut(2'b00, 1'b0, 1'b0);
        count(800);
        check_near(n_osc, 200, 2);
        // Clock output stays off while the crystal is in use.
        for (int k = 0; k < 2; k++)
        begin
            reset_dut(k == 0 ? 2'b10 : 2'b01, 1'b0, k == 1);
            axi_write(`MCG_OFF_TUNING, 32'h40, 4'hf, `MCG_RESP_OKAY);
            count(200);
            check_near(n_osc, k == 0 ? 50 : 93, 2);
            check(clock_output_pin_oe_n_o, 1'b1);
            check(n_pin, 0);
        end
        results();
    end
endmodule : test_mcu_clock_generation

// Port checker attached to every clock generation top.
bind mcg_top mcg_top_asserts #(.DIV_W(DIV_W)) chk_u (.*);

// ### hdl/mcg_clk_div.sv
// CPU clock divider: one CPU tick per 2N oscillator ticks, or per tick when N is zero.
`timescale 1ns/1ps
module mcg_clk_div #(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Oscillator tick and divide value.
    input wire logic osc_tick_i,
    input wire logic [DIV_W-1:0] divide_i,
    // CPU tick.
    output logic cpu_tick_o
);
    logic [DIV_W:0] count;
    logic [DIV_W:0] terminal;
    logic bypass;
    logic wrap;

    // A shrinking divide value wraps at once rather than running past it.
    assign terminal = {divide_i, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
    assign bypass = (divide_i == '0);
    assign wrap = bypass || (count >= terminal);

    // Count oscillator ticks and emit the CPU tick on wrap.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            count <= '0;
            cpu_tick_o <= 1'b0;
        end
        else
        begin
            cpu_tick_o <= osc_tick_i && wrap;
            if (osc_tick_i)
            begin
                count <= wrap ? '0 : count + {{DIV_W{1'b0}}, 1'b1};
            end
        end
    end
endmodule : mcg_clk_div

// ### hdl/mcg_rc_osc.sv
// Internal RC oscillator model: phase accumulator giving one tick per RC cycle.
`timescale 1ns/1ps
`include "mcg_cfg.svh"
module mcg_rc_osc #(
    parameter int NCO_W = `MCG_NCO_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Tuning.
    input wire logic [5:0] trim_i,
    input wire logic doubler_i,
    // Oscillator tick.
    output logic rc_tick_o
);
    logic [NCO_W-1:0] phase;
    logic [31:0] base_khz;
    logic [31:0] freq_khz;
    logic [31:0] inc_wide;
    logic [NCO_W:0] sum;

    // Frequency falls as the trim value rises, nominal at the mid value.
    assign base_khz = 32'(`MCG_RC_NOM_KHZ)
        + (32'(`MCG_RC_TRIM_MID) - 32'(trim_i)) * 32'(`MCG_RC_TRIM_STEP_KHZ);
    assign freq_khz = doubler_i ? {base_khz[30:0], 1'b0} : base_khz;
    assign inc_wide = (freq_khz << NCO_W) / 32'(`MCG_SYS_CLK_KHZ);
    assign sum = {1'b0, phase} + {1'b0, inc_wide[NCO_W-1:0]};

    // Accumulator carry marks one RC cycle.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            phase <= '0;
            rc_tick_o <= 1'b0;
        end
        else
        begin
            phase <= sum[NCO_W-1:0];
            rc_tick_o <= sum[NCO_W];
        end
    end
endmodule : mcg_rc_osc

// ### hdl/mcg_top.sv
// Clock generation top: source selection, CPU and peripheral ticks, clock output, registers.
`timescale 1ns/1ps
`include "mcg_cfg.svh"
module mcg_top #(
    parameter int DIV_W = `MCG_DIV_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // AXI4-Lite write address and data.
    input wire logic [`MCG_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read.
    input wire logic [`MCG_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Nonvolatile configuration and factory calibration.
    input wire logic [1:0] cfg_src_i,
    input wire logic cfg_doubler_i,
    input wire logic rtc_uses_xtal_i,
    input wire logic [5:0] factory_trim_i,
    // Oscillator inputs from outside the clock domain.
    input wire logic xtal_osc_i,
    input wire logic ext_clk_i,
    input wire logic wdt_osc_i,
    // Clock ticks.
    output logic osc_tick_o,
    output logic cpu_tick_o,
    output logic machine_tick_o,
    output logic periph_tick_o,
    // Clock output pin and low-power setting.
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_n_o,
    output logic low_power_clock_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int NPIN = 3;
    localparam int PIN_XTAL = 0;
    localparam int PIN_EXT = 1;
    localparam int PIN_WDT = 2;

    mcg_pkg::mcg_cfg_t cfg;
    mcg_pkg::mcg_tuning_t tuning;
    logic [DIV_W-1:0] cpu_clock_divider;
    logic low_power_clock;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] pin_last;
    logic [NPIN-1:0] pin_rise;
    logic rc_tick;
    logic src_tick;
    logic next_osc_tick;
    logic cpu_tick;
    logic cpu_phase;
    logic clk_out_active;
    logic clk_out_level;

    logic wr_fire;
    logic wr_hit_tuning;
    logic wr_hit_divider;
    logic wr_hit_aux1;
    logic wr_hit_status;
    logic wr_mapped;
    logic rd_fire;
    logic [31:0] rd_word;
    logic rd_mapped;
    logic [31:0] status_word;

    // ****************************************************************
    // Configuration capture
    // ****************************************************************

    // Configuration is taken from the nonvolatile bits while reset is held.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cfg.src <= mcg_pkg::mcg_src_t'(cfg_src_i);
            cfg.doubler <= cfg_doubler_i;
            cfg.rtc_uses_xtal <= rtc_uses_xtal_i;
        end
    end

    // ****************************************************************
    // Oscillator input synchronisers
    // ****************************************************************
    assign pin_raw[PIN_XTAL] = xtal_osc_i;
    assign pin_raw[PIN_EXT] = ext_clk_i;
    assign pin_raw[PIN_WDT] = wdt_osc_i;

    // Two flops per pin, then a third flop for the rising edge.
    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                    pin_last[i] <= 1'b0;
                end
                else
                begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                    pin_last[i] <= pin_sync[i];
                end
            end
            assign pin_rise[i] = pin_sync[i] && !pin_last[i];
        end
    endgenerate

    // ****************************************************************
    // Oscillator clock selection
    // ****************************************************************

    // The internal RC oscillator.
    mcg_rc_osc #(
        .NCO_W(`MCG_NCO_W)
    ) u_rc_osc (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .trim_i(tuning.trim),
        .doubler_i(cfg.doubler),
        .rc_tick_o(rc_tick)
    );

    // Exactly one configured source feeds the oscillator clock.
    always_comb
    begin
        case (cfg.src)
            mcg_pkg::MCG_SRC_WDT: src_tick = pin_rise[PIN_WDT];
            mcg_pkg::MCG_SRC_RC: src_tick = rc_tick;
            mcg_pkg::MCG_SRC_XTAL: src_tick = pin_rise[PIN_XTAL];
            mcg_pkg::MCG_SRC_EXT: src_tick = pin_rise[PIN_EXT];
            default: src_tick = 1'b0;
        endcase
    end

    // The RC select bit overrides the configured source with no reset needed.
    assign next_osc_tick = tuning.rc_clock_select ? rc_tick : src_tick;

    // Oscillator tick is registered before it leaves the block.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            osc_tick_o <= 1'b0;
        end
        else
        begin
            osc_tick_o <= next_osc_tick;
        end
    end

    // ****************************************************************
    // CPU, machine and peripheral clocks
    // ****************************************************************

    // The divider forms the CPU clock from the oscillator clock.
    mcg_clk_div #(
        .DIV_W(DIV_W)
    ) u_clk_div (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .osc_tick_i(next_osc_tick),
        .divide_i(cpu_clock_divider),
        .cpu_tick_o(cpu_tick)
    );

    assign cpu_tick_o = cpu_tick;

    // Two CPU cycles make one machine cycle and one peripheral clock cycle.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cpu_phase <= 1'b0;
            machine_tick_o <= 1'b0;
            periph_tick_o <= 1'b0;
        end
        else
        begin
            if (cpu_tick)
            begin
                cpu_phase <= !cpu_phase;
            end
            machine_tick_o <= cpu_tick && cpu_phase;
            periph_tick_o <= cpu_tick && !cpu_phase;
        end
    end

    // ****************************************************************
    // Clock output pin
    // ****************************************************************

    // The pin is driven only when enabled and the crystal serves nobody.
    assign clk_out_active = tuning.clock_out_enable
        && (cfg.src != mcg_pkg::MCG_SRC_XTAL)
        && !cfg.rtc_uses_xtal;

    // The level toggles on every CPU tick, giving half the CPU clock.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            clk_out_level <= 1'b0;
            clock_output_pin_oe_n_o <= 1'b1;
        end
        else
        begin
            clock_output_pin_oe_n_o <= !clk_out_active;
            if (!clk_out_active)
            begin
                clk_out_level <= 1'b0;
            end
            else if (cpu_tick)
            begin
                clk_out_level <= !clk_out_level;
            end
        end
    end

    assign clock_output_pin_o = clk_out_level;
    assign low_power_clock_o = low_power_clock;

    // ****************************************************************
    // Register bus decode
    // ****************************************************************

    // Address and data are taken together once no response is pending.
    assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
    assign s_axi_awready_o = wr_fire;
    assign s_axi_wready_o = wr_fire;
    assign wr_hit_tuning = wr_fire && (s_axi_awaddr_i == `MCG_OFF_TUNING) && s_axi_wstrb_i[0];
    assign wr_hit_divider = wr_fire && (s_axi_awaddr_i == `MCG_OFF_DIVIDER) && s_axi_wstrb_i[0];
    assign wr_hit_aux1 = wr_fire && (s_axi_awaddr_i == `MCG_OFF_AUX1) && s_axi_wstrb_i[0];
    assign wr_hit_status = (s_axi_awaddr_i == `MCG_OFF_STATUS);
    assign wr_mapped = (s_axi_awaddr_i == `MCG_OFF_TUNING)
        || (s_axi_awaddr_i == `MCG_OFF_DIVIDER)
        || (s_axi_awaddr_i == `MCG_OFF_AUX1)
        || wr_hit_status;

    // Reads are taken when no read data is pending.
    assign rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
    assign s_axi_arready_o = rd_fire;

    // Status shows the configured source and the live output state.
    assign status_word = {
        24'h000000,
        low_power_clock,
        clk_out_active,
        tuning.rc_clock_select,
        1'b0,
        cfg.rtc_uses_xtal,
        cfg.doubler,
        cfg.src
    };

    // Read data selection; unmapped offsets read zero with an error.
    assign rd_mapped = (s_axi_araddr_i == `MCG_OFF_TUNING)
        || (s_axi_araddr_i == `MCG_OFF_DIVIDER)
        || (s_axi_araddr_i == `MCG_OFF_AUX1)
        || (s_axi_araddr_i == `MCG_OFF_STATUS);
    assign rd_word = (s_axi_araddr_i == `MCG_OFF_TUNING) ? {24'h000000, tuning}
        : (s_axi_araddr_i == `MCG_OFF_DIVIDER) ? {{(32-DIV_W){1'b0}}, cpu_clock_divider}
        : (s_axi_araddr_i == `MCG_OFF_AUX1) ? {24'h000000, low_power_clock, 7'h00}
        : (s_axi_araddr_i == `MCG_OFF_STATUS) ? status_word
        : 32'h00000000;

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Tuning register: control bits clear and the trim reloads on reset.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tuning.rc_clock_select <= `MCG_TUN_CTRL_RST;
            tuning.clock_out_enable <= `MCG_TUN_CTRL_RST;
            tuning.trim <= factory_trim_i;
        end
        else if (wr_hit_tuning)
        begin
            tuning <= s_axi_wdata_i[7:0];
        end
    end

    // Divider and low-power registers.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cpu_clock_divider <= DIV_W'(`MCG_DIVIDER_RST);
            low_power_clock <= `MCG_LOW_POWER_RST;
        end
        else
        begin
            if (wr_hit_divider)
            begin
                cpu_clock_divider <= s_axi_wdata_i[DIV_W-1:0];
            end
            if (wr_hit_aux1)
            begin
                low_power_clock <= s_axi_wdata_i[`MCG_AUX1_LOW_POWER];
            end
        end
    end

    // ****************************************************************
    // Bus responses
    // ****************************************************************

    // Write response one cycle after the write is taken.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `MCG_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_mapped ? `MCG_RESP_OKAY : `MCG_RESP_DECERR;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read data one cycle after the address is taken.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `MCG_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_mapped ? `MCG_RESP_OKAY : `MCG_RESP_DECERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule : mcg_top

// ### inc/mcg_cfg.svh
// Constants of the clock generation block: offsets, fields, reset values and rates.
`ifndef MCG_CFG_SVH
`define MCG_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MCG_ADDR_W 8
`define MCG_OFF_TUNING 8'h00
`define MCG_OFF_DIVIDER 8'h04
`define MCG_OFF_AUX1 8'h08
`define MCG_OFF_STATUS 8'h0c

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MCG_AUX1_LOW_POWER 7
`define MCG_DIVIDER_RST 8'h00
`define MCG_LOW_POWER_RST 1'b0
`define MCG_TUN_CTRL_RST 1'b0
`define MCG_RESP_OKAY 2'b00
`define MCG_RESP_DECERR 2'b11

// ****************************************************************
// Rates
// ****************************************************************
`define MCG_SYS_CLK_KHZ 20000
`define MCG_RC_NOM_KHZ 7373
`define MCG_RC_TRIM_STEP_KHZ 60
`define MCG_RC_TRIM_MID 32
`define MCG_NCO_W 16
`define MCG_DIV_W 8

`endif

// ### inc/mcg_pkg.sv
// Types shared by the clock generation block.
package mcg_pkg;

    // Oscillator sources selectable by nonvolatile configuration.
    typedef enum logic [1:0] {
        MCG_SRC_WDT = 2'b00,
        MCG_SRC_RC = 2'b01,
        MCG_SRC_XTAL = 2'b10,
        MCG_SRC_EXT = 2'b11
    } mcg_src_t;

    // Tuning register layout.
    typedef struct packed {
        logic rc_clock_select;
        logic clock_out_enable;
        logic [5:0] trim;
    } mcg_tuning_t;

    // Configuration captured during reset.
    typedef struct packed {
        mcg_src_t src;
        logic doubler;
        logic rtc_uses_xtal;
    } mcg_cfg_t;

endpackage : mcg_pkg
